// ### hdl/cycle_timer.sv
// Loadable down counter that pulses once when its count runs out
`timescale 1ns/100ps
`default_nettype none

module cycle_timer
  import rail_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic load_i,
  input wire logic [23:0] value_i,
  // Status
  output logic busy_o,
  output logic expire_o
);

  timer_state_t st;
  timer_state_t next_st;

  // ****************************************************************
  // Counting
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.expire = 1'b0;
    if (load_i) begin
      next_st.busy = 1'b1;
      next_st.count = value_i;
    end else if (st.busy) begin
      if (st.count <= 24'h000001) begin
        next_st.busy = 1'b0;
        next_st.expire = 1'b1;
      end else begin
        next_st.count = st.count - 24'h000001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = st.busy;
  assign expire_o = st.expire;

endmodule : cycle_timer
`default_nettype wire

// ### hdl/rail_slew_and_strobe_timing.sv
// Buck rail stepping, aux set-point blanking and strobe gap timing
`timescale 1ns/100ps
`default_nettype none
`include "rail_timing_defs.svh"

module rail_slew_and_strobe_timing
  import rail_timing_pkg::*;
#(
  parameter int CODE_W = 6,
  parameter logic [23:0] STEP_CODE0_CYCLES = 24'(`STEP_TIME_CODE0_NS / `CLK_PERIOD_NS),
  parameter logic [23:0] GAP_SHORT_CYCLES = 24'(`GAP_SHORT_NS / `CLK_PERIOD_NS),
  parameter logic [23:0] GAP_LONG_CYCLES = 24'(`GAP_LONG_NS / `CLK_PERIOD_NS),
  parameter logic [23:0] BLANK_CYCLES = 24'(`BLANK_TIME_NS / `CLK_PERIOD_NS)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register access
  input wire reg_req_t reg_req_i,
  input wire logic unlock_i,
  output logic [7:0] rdata_o,
  // Buck rail targets
  input wire logic buck_setpoint_wr_i,
  input wire logic [5:0] buck_one_target_i,
  input wire logic [5:0] buck_two_target_i,
  // Buck rail applied codes
  output logic [5:0] buck_one_code_o,
  output logic [5:0] buck_two_code_o,
  output logic slew_busy_o,
  // Aux regulator
  output logic [5:0] aux_code_o,
  output logic aux_monitor_blank_o,
  // Sequencer
  input wire logic seq_up_start_i,
  input wire logic seq_down_start_i,
  output logic [3:0] strobe_index_o,
  output logic strobe_pulse_o,
  output logic seq_busy_o
);

  logic [1:0] rst_sync;
  logic rst_n;
  rail_state_t st;
  rail_state_t next_st;
  logic step_load;
  logic [23:0] step_value;
  logic step_expire;
  logic gap_load;
  logic [23:0] gap_value;
  logic gap_expire;
  logic blank_load;
  logic blank_expire;
  logic [8:0] gap_sel;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************************************
  // Timers
  // ****************************************************************
  cycle_timer u_step_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(step_load),
    .value_i(step_value),
    .busy_o(),
    .expire_o(step_expire)
  );

  cycle_timer u_gap_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(gap_load),
    .value_i(gap_value),
    .busy_o(),
    .expire_o(gap_expire)
  );

  cycle_timer u_blank_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(blank_load),
    .value_i(BLANK_CYCLES),
    .busy_o(),
    .expire_o(blank_expire)
  );

  assign gap_sel = {st.gap9, st.gap_low};

  function automatic logic [23:0] gap_cycles(input logic sel, input logic down, input logic mult);
    logic [23:0] base;
    base = sel ? GAP_LONG_CYCLES : GAP_SHORT_CYCLES;
    gap_cycles = (down && mult) ? 24'(base * `GAP_DOWN_FACTOR) : base;
  endfunction : gap_cycles

  function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] tgt);
    if (cur < tgt) begin
      step_toward = cur + 6'h01;
    end else if (cur > tgt) begin
      step_toward = cur - 6'h01;
    end else begin
      step_toward = cur;
    end
  endfunction : step_toward

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic wr;
    logic start;
    logic [5:0] one_n;
    logic [5:0] two_n;
    wr = 1'b0;
    start = 1'b0;
    one_n = 6'h00;
    two_n = 6'h00;
    next_st = st;
    next_st.strobe_pulse = 1'b0;
    step_load = 1'b0;
    step_value = STEP_CODE0_CYCLES >> st.slew_code;
    gap_load = 1'b0;
    gap_value = 24'h000000;
    blank_load = 1'b0;
    wr = reg_req_i.wr;

    // Slew engine completion, only buck rails one and two are stepped
    if (st.moving && step_expire) begin
      one_n = step_toward(st.buck_one, buck_one_target_i);
      two_n = step_toward(st.buck_two, buck_two_target_i);
      next_st.buck_one = one_n;
      next_st.buck_two = two_n;
      if (one_n == buck_one_target_i && two_n == buck_two_target_i) begin
        next_st.moving = 1'b0;
        next_st.trigger = 1'b0;
      end else begin
        step_load = 1'b1;
      end
    end

    // Register writes
    if (wr && reg_req_i.addr == `OFS_RAIL_SLEW_CONTROL) begin
      next_st.bypass = reg_req_i.wdata[`SLEW_BYPASS_BIT];
      next_st.slew_code = reg_req_i.wdata[2:0];
      step_value = STEP_CODE0_CYCLES >> reg_req_i.wdata[2:0];
      if (reg_req_i.wdata[`SLEW_TRIGGER_BIT]) begin
        next_st.trigger = 1'b1;
        start = 1'b1;
      end
    end
    if (wr && unlock_i) begin
      if (reg_req_i.addr == `OFS_AUX_REGULATOR_SETPOINT) begin
        next_st.aux_code = reg_req_i.wdata[5:0];
        next_st.blank = 1'b1;
        blank_load = 1'b1;
      end
      if (reg_req_i.addr == `OFS_STROBE_GAP_SELECT_LOW) begin
        next_st.gap_low = reg_req_i.wdata;
      end
      if (reg_req_i.addr == `OFS_STROBE_GAP_SELECT_HIGH) begin
        next_st.mult = reg_req_i.wdata[`GAP_HIGH_MULT_BIT];
        next_st.gap9 = reg_req_i.wdata[`GAP_HIGH_SEL9_BIT];
      end
    end
    if (blank_expire && !blank_load) begin
      next_st.blank = 1'b0;
    end

    // Transition start by trigger or bypassed set-point write
    if (st.bypass && buck_setpoint_wr_i) begin
      start = 1'b1;
    end
    if (start) begin
      if (next_st.slew_code == `SLEW_CODE_IMMEDIATE) begin
        next_st.buck_one = buck_one_target_i;
        next_st.buck_two = buck_two_target_i;
        next_st.moving = 1'b0;
        next_st.trigger = 1'b0;
        step_load = 1'b0;
      end else begin
        next_st.moving = 1'b1;
        step_load = 1'b1;
      end
    end

    // Strobe sequencer
    unique case (st.seq)
      SEQ_IDLE: begin
        if (seq_up_start_i) begin
          next_st.seq = SEQ_UP;
          next_st.strobe_index = `STROBE_FIRST;
          next_st.strobe_pulse = 1'b1;
          gap_load = 1'b1;
          gap_value = gap_cycles(gap_sel[0], 1'b0, st.mult);
        end else if (seq_down_start_i) begin
          next_st.seq = SEQ_DOWN;
          next_st.strobe_index = `STROBE_LAST;
          next_st.strobe_pulse = 1'b1;
          gap_load = 1'b1;
          gap_value = gap_cycles(gap_sel[8], 1'b1, st.mult);
        end
      end
      SEQ_UP: begin
        if (gap_expire) begin
          next_st.strobe_index = st.strobe_index + 4'h1;
          next_st.strobe_pulse = 1'b1;
          if (st.strobe_index + 4'h1 == `STROBE_LAST) begin
            next_st.seq = SEQ_IDLE;
          end else begin
            gap_load = 1'b1;
            gap_value = gap_cycles(gap_sel[st.strobe_index], 1'b0, st.mult);
          end
        end
      end
      SEQ_DOWN: begin
        if (gap_expire) begin
          next_st.strobe_index = st.strobe_index - 4'h1;
          next_st.strobe_pulse = 1'b1;
          if (st.strobe_index - 4'h1 == `STROBE_FIRST) begin
            next_st.seq = SEQ_IDLE;
          end else begin
            gap_load = 1'b1;
            gap_value = gap_cycles(gap_sel[st.strobe_index - 4'h3], 1'b1, st.mult);
          end
        end
      end
      default: begin
        next_st.seq = SEQ_IDLE;
      end
    endcase

    // Register reads
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        `OFS_RAIL_SLEW_CONTROL: next_st.rdata = {st.trigger, st.bypass, 3'h0, st.slew_code};
        `OFS_AUX_REGULATOR_SETPOINT: next_st.rdata = {2'h0, st.aux_code};
        `OFS_STROBE_GAP_SELECT_LOW: next_st.rdata = st.gap_low;
        `OFS_STROBE_GAP_SELECT_HIGH: next_st.rdata = {st.mult, 6'h00, st.gap9};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.slew_code <= `SLEW_CODE_RESET;
      st.aux_code <= `AUX_CODE_RESET;
      st.gap_low <= `GAP_LOW_RESET;
      st.mult <= 1'(`GAP_HIGH_RESET >> `GAP_HIGH_MULT_BIT);
      st.gap9 <= 1'b0;
      st.seq <= SEQ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_o = st.rdata;
  assign buck_one_code_o = st.buck_one;
  assign buck_two_code_o = st.buck_two;
  assign slew_busy_o = st.moving;
  assign aux_code_o = st.aux_code;
  assign aux_monitor_blank_o = st.blank;
  assign strobe_index_o = st.strobe_index;
  assign strobe_pulse_o = st.strobe_pulse;
  assign seq_busy_o = st.seq[0];

endmodule : rail_slew_and_strobe_timing
`default_nettype wire

// ### hdl/rail_timing_defs.svh
// Offsets, field positions, reset values and timing figures of the rail timing block
// Behaviour
// - Step-time code 0 dwells 160 us per code step, each higher code halves it.
// - Step-time field resets to code 6, giving 2.5 us per code step.
// - Step-time code 7 applies the new set-point at once, no stepping.
// - Step time fixes dwell per code only; slope follows volts per code.
// - Aux set-point and both sequencer registers accept writes only when unlocked.
// - Each aux set-point write blanks that rail's voltage monitoring for 5 ms.
// - Aux codes 0-19h step 25 mV from 0.900 V, 1Ah-3Fh step 50 mV to 3.400 V.
// - Aux set-point register sits at 1Bh and resets to 33h (2.800 V).
// - Each gap selector waits 2 ms when 0 and 5 ms when 1.
// - First sequencer register bit 7 follows strobe 8, bit 0 follows strobe 1.
// - First sequencer register sits at 20h and resets to 00h.
// - Second sequencer register sits at 21h and resets to 00h.
// - Writing trigger 1 steps both buck rails to targets; clears when done.
// - With trigger bypass set, each buck set-point write starts a stepped transition.
// - Stepping applies only to buck rails one and two.
// - Shutdown gap multiplier stretches power-down gaps tenfold, never power-up gaps.
`ifndef RAIL_TIMING_DEFS_SVH
`define RAIL_TIMING_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_RAIL_SLEW_CONTROL 8'h1A
`define OFS_AUX_REGULATOR_SETPOINT 8'h1B
`define OFS_STROBE_GAP_SELECT_LOW 8'h20
`define OFS_STROBE_GAP_SELECT_HIGH 8'h21

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SLEW_TRIGGER_BIT 7
`define SLEW_BYPASS_BIT 6
`define SLEW_CODE_RESET 3'h6
`define SLEW_CODE_IMMEDIATE 3'h7
`define AUX_CODE_RESET 6'h33
`define GAP_LOW_RESET 8'h00
`define GAP_HIGH_RESET 8'h00
`define GAP_HIGH_MULT_BIT 7
`define GAP_HIGH_SEL9_BIT 0

// ****************************************************************
// Timing figures
// ****************************************************************
`define CLK_PERIOD_NS 4
`define STEP_TIME_CODE0_NS 160000
`define GAP_SHORT_NS 2000000
`define GAP_LONG_NS 5000000
`define BLANK_TIME_NS 5000000
`define GAP_DOWN_FACTOR 10
`define STROBE_LAST 4'hA
`define STROBE_FIRST 4'h1

`endif

// ### hdl/rail_timing_pkg.sv
// Types shared by the rail timing block
package rail_timing_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_UP = 2'b01,
    SEQ_DOWN = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic busy;
    logic expire;
    logic [23:0] count;
  } timer_state_t;

  typedef struct packed {
    logic trigger;
    logic bypass;
    logic [2:0] slew_code;
    logic moving;
    logic [5:0] aux_code;
    logic [7:0] gap_low;
    logic mult;
    logic gap9;
    logic blank;
    logic [5:0] buck_one;
    logic [5:0] buck_two;
    seq_state_t seq;
    logic [3:0] strobe_index;
    logic strobe_pulse;
    logic [7:0] rdata;
  } rail_state_t;

endpackage : rail_timing_pkg

// ### verification/host_model.sv
// Host model issuing register accesses on the sub-address port
`timescale 1ns/100ps
`default_nettype none

module host_model
  import rail_timing_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register access
  output reg_req_t req_o,
  output logic unlock_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    req_o = '0;
    unlock_o = 1'b0;
  end

  // Protection is satisfied or not in the same cycle the write is presented
  task automatic write(input logic [7:0] addr, input logic [7:0] data, input logic unl);
    @(posedge clk_i);
    #1;
    unlock_o = unl;
    req_o = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_i);
    #1;
    req_o.wr = 1'b0;
    req_o.addr = ~req_o.addr;
    req_o.wdata = ~req_o.wdata;
  endtask : write

  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_i);
    #1;
    req_o.rd = 1'b1;
    req_o.addr = addr;
    @(posedge clk_i);
    #1;
    req_o.rd = 1'b0;
    req_o.addr = ~req_o.addr;
    data = rdata_i;
  endtask : read
endmodule : host_model
`default_nettype wire

// ### verification/rail_timing_props.sv
// Assertion checker for the rail timing block
`timescale 1ns/100ps
`default_nettype none
`include "rail_timing_defs.svh"

module rail_timing_props
  import rail_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Inputs
  input wire reg_req_t reg_req_i,
  input wire logic unlock_i,
  input wire logic [5:0] buck_one_target_i,
  input wire logic [5:0] buck_two_target_i,
  input wire logic seq_up_start_i,
  input wire logic seq_down_start_i,
  // Outputs
  input wire logic [5:0] buck_one_code_o,
  input wire logic [5:0] buck_two_code_o,
  input wire logic slew_busy_o,
  input wire logic [5:0] aux_code_o,
  input wire logic aux_monitor_blank_o,
  input wire logic [3:0] strobe_index_o,
  input wire logic strobe_pulse_o,
  input wire logic seq_busy_o
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic aux_wr;
  logic slew_wr;
  assign aux_wr = reg_req_i.wr && reg_req_i.addr == `OFS_AUX_REGULATOR_SETPOINT;
  assign slew_wr = reg_req_i.wr && reg_req_i.addr == `OFS_RAIL_SLEW_CONTROL;

  chk_aux_write_lands: assert property (aux_wr && unlock_i |=> aux_code_o == $past(reg_req_i.wdata[5:0]))
    else $error("aux code not taken");
  chk_aux_locked_hold: assert property (aux_wr && !unlock_i |=> $stable(aux_code_o))
    else $error("locked aux write changed code");
  chk_blank_window: assert property (aux_wr && unlock_i |=> aux_monitor_blank_o [*8])
    else $error("monitor blanking missing");
  chk_slew_immediate: assert property (slew_wr && reg_req_i.wdata[7] && reg_req_i.wdata[2:0] == 3'h7
    |=> buck_one_code_o == $past(buck_one_target_i) && buck_two_code_o == $past(buck_two_target_i))
    else $error("immediate code not applied");
  chk_slew_starts: assert property (slew_wr && reg_req_i.wdata[7] && reg_req_i.wdata[2:0] != 3'h7
    && buck_one_code_o != buck_one_target_i |=> slew_busy_o)
    else $error("stepping did not start");
  chk_step_single: assert property ($past(slew_busy_o) && $changed(buck_one_code_o)
    |-> 6'(buck_one_code_o - $past(buck_one_code_o)) inside {6'h01, 6'h3F})
    else $error("code moved more than one step");
  chk_strobe_single: assert property (strobe_pulse_o |=> !strobe_pulse_o [*8])
    else $error("strobe pulse too long");
  chk_up_first: assert property (seq_up_start_i && !seq_busy_o
    |=> strobe_pulse_o && strobe_index_o == 4'h1)
    else $error("power-up first strobe wrong");
  chk_down_first: assert property (seq_down_start_i && !seq_up_start_i && !seq_busy_o
    |=> strobe_pulse_o && strobe_index_o == 4'hA)
    else $error("power-down first strobe wrong");

  cover property (strobe_pulse_o && strobe_index_o == 4'hA);
  cover property ($fell(slew_busy_o));
  cover property ($fell(aux_monitor_blank_o));
endmodule : rail_timing_props

bind rail_slew_and_strobe_timing rail_timing_props chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reg_req_i(reg_req_i), .unlock_i(unlock_i), .buck_one_target_i(buck_one_target_i),
  .buck_two_target_i(buck_two_target_i), .seq_up_start_i(seq_up_start_i),
  .seq_down_start_i(seq_down_start_i), .buck_one_code_o(buck_one_code_o),
  .buck_two_code_o(buck_two_code_o), .slew_busy_o(slew_busy_o), .aux_code_o(aux_code_o),
  .aux_monitor_blank_o(aux_monitor_blank_o), .strobe_index_o(strobe_index_o),
  .strobe_pulse_o(strobe_pulse_o), .seq_busy_o(seq_busy_o));
`default_nettype wire

// ### verification/test_rail_slew_and_strobe_timing.sv
// Testbench of the rail timing block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", what, exp, got); end end

module test_rail_slew_and_strobe_timing
  import rail_timing_pkg::*;
;
  localparam int STEP0 = 64;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  reg_req_t req;
  logic unlock;
  logic [7:0] rdata;
  logic buck_wr = 1'b0;
  logic [5:0] t1 = 6'h00;
  logic [5:0] t2 = 6'h00;
  logic [5:0] c1, c2, aux;
  logic busy, blank, up = 1'b0, dn = 1'b0, pulse, sbusy;
  logic [3:0] index;
  int num_errors = 0;
  int compares = 0;

  always #2 clk_i = ~clk_i;

  rail_slew_and_strobe_timing #(.STEP_CODE0_CYCLES(24'(STEP0)), .GAP_SHORT_CYCLES(24'h14),
    .GAP_LONG_CYCLES(24'h32), .BLANK_CYCLES(24'h1E)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(req), .unlock_i(unlock), .rdata_o(rdata), .buck_setpoint_wr_i(buck_wr),
    .buck_one_target_i(t1), .buck_two_target_i(t2), .buck_one_code_o(c1), .buck_two_code_o(c2),
    .slew_busy_o(busy), .aux_code_o(aux), .aux_monitor_blank_o(blank), .seq_up_start_i(up),
    .seq_down_start_i(dn), .strobe_index_o(index), .strobe_pulse_o(pulse), .seq_busy_o(sbusy));
  host_model host_u (.clk_i(clk_i), .req_o(req), .unlock_o(unlock), .rdata_i(rdata));

  // ****
  // Scenarios
  // ****
  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read(addr, d);
    `CHECK("read data", exp, d)
  endtask : rchk

  task automatic count_high(ref logic sig, output int n);
    n = 0;
    while (sig === 1'b1 && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask : count_high

  task automatic test_regs();
    `CHECK("aux code", 6'h33, aux)
    rchk(8'h1A, 8'h06);
    rchk(8'h1B, 8'h33);
    rchk(8'h20, 8'h00);
    rchk(8'h21, 8'h00);
    rchk(8'h30, 8'h00);
    host_u.write(8'h1B, 8'h10, 1'b0);
    `CHECK("blank", 1'b0, blank)
    rchk(8'h1B, 8'h33);
    host_u.write(8'h20, 8'hA5, 1'b0);
    rchk(8'h20, 8'h00);
    host_u.write(8'h20, 8'hA5, 1'b1);
    rchk(8'h20, 8'hA5);
    host_u.write(8'h21, 8'hFF, 1'b1);
    rchk(8'h21, 8'h81);
    host_u.write(8'h1A, 8'h3D, 1'b1);
    rchk(8'h1A, 8'h05);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_blank();
    int n;
    host_u.write(8'h1B, 8'hFF, 1'b1);
    rchk(8'h1B, 8'h3F);
    host_u.write(8'h1B, 8'h19, 1'b1);
    `CHECK("aux code", 6'h19, aux)
    count_high(blank, n);
    `CHECK("blank cycles", 31, n)
    $display("test_blank done");
  endtask : test_blank

  task automatic test_slew();
    int n;
    t1 = 6'h05;
    t2 = 6'h03;
    host_u.write(8'h1A, 8'h87, 1'b1);
    @(posedge clk_i);
    #1;
    `CHECK("immediate codes", {6'h05, 6'h03}, {c1, c2})
    for (int c = 5; c <= 6; c++) begin
      t1 = (c == 5) ? 6'h08 : 6'h05;
      t2 = (c == 5) ? 6'h01 : 6'h03;
      host_u.write(8'h1A, {5'h10, 3'(c)}, 1'b1);
      count_high(busy, n);
      `CHECK("step cycles", ((STEP0 >> c) + 1) * 3, n)
      `CHECK("stepped codes", {t1, t2}, {c1, c2})
      rchk(8'h1A, {5'h00, 3'(c)});
    end
    host_u.write(8'h1A, 8'h46, 1'b1);
    t1 = 6'h07;
    #4;
    buck_wr = 1'b1;
    @(posedge clk_i);
    #1;
    buck_wr = 1'b0;
    count_high(busy, n);
    `CHECK("bypass codes", {6'h07, 6'h03}, {c1, c2})
    `CHECK("bypass cycles", 4, n)
    $display("test_slew done");
  endtask : test_slew

  task automatic run_seq(input logic go_up, input logic [8:0] sel, input logic mult);
    int n;
    int idx;
    int exp;
    repeat (10) @(posedge clk_i);
    #1;
    up = go_up;
    dn = !go_up;
    for (int k = 1; k <= 10; k++) begin
      idx = go_up ? k : 11 - k;
      exp = (k == 1) ? 1 :
        (sel[go_up ? idx - 2 : idx - 1] ? 50 : 20) * ((!go_up && mult) ? 10 : 1) + 1;
      n = 0;
      do begin
        @(posedge clk_i);
        #1;
        n++;
      end while (pulse !== 1'b1 && n < 6000);
      up = 1'b0;
      dn = 1'b0;
      `CHECK("strobe gap", exp, n)
      `CHECK("strobe index", 4'(idx), index)
    end
    `CHECK("sequencer busy", 1'b0, sbusy)
  endtask : run_seq

  task automatic test_seq();
    host_u.write(8'h20, 8'h81, 1'b1);
    host_u.write(8'h21, 8'h81, 1'b1);
    run_seq(1'b1, 9'h181, 1'b1);
    run_seq(1'b0, 9'h181, 1'b1);
    $display("test_seq done");
  endtask : test_seq

  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    test_regs();
    test_blank();
    test_slew();
    test_seq();
    summarize();
  end
endmodule : test_rail_slew_and_strobe_timing
`default_nettype wire
